/* test/ebi_core_sva.sv */
// Checker for the external bus interface core, bound to every instance.
// Assumes one clock domain and sees the core's ports only.
`timescale 1ns/100ps
`default_nettype none
module ebi_core_chk (
  // Clock and reset.
  input wire sys_clk,
  input wire reset_n,
  // Inputs seen by the core.
  input wire [1:0] cfg_mode,
  input wire [15:0] cfg_divider,
  input wire [7:0] cfg_max_wait,
  input wire [2:0] int_enable,
  input wire str_start,
  input wire ext_ack,
  // Outputs of the core.
  input wire [1:0] ext_mode_r,
  input wire ext_clk_r,
  input wire ext_req_r,
  input wire [31:0] ext_addr_r,
  input wire [2:0] wr_free_r,
  input wire [3:0] rd_avail_r,
  input wire [15:0] str_remain_r,
  input wire [2:0] int_raw_r,
  input wire [2:0] int_masked_r,
  input wire [2:0] err_status_r,
  input wire dma_req_r
);
  // ---
  // Properties
  // ---
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // A steady mode selection shows on the bus.
  a_mode_echo: assert property ($stable(cfg_mode) |-> ext_mode_r == cfg_mode)
    else $error("bus mode differs from selection");
  // The smallest divider makes the bus clock flip every cycle.
  a_clk_flip: assert property (cfg_divider == 16'h0000 &&
    $past(cfg_divider) == 16'h0000 && $past(reset_n, 2)
    |-> ext_clk_r != $past(ext_clk_r)) else $error("bus clock stuck");
  // Without a wait limit a request and its address stand until answered.
  a_req_hold: assert property (ext_req_r && !ext_ack &&
    cfg_max_wait == 8'h00 |=> ext_req_r && $stable(ext_addr_r))
    else $error("request changed before answer");
  // An answered request is released at the next edge.
  a_req_drop: assert property (ext_req_r && ext_ack |=> !ext_req_r)
    else $error("request held after answer");
  a_free_bound: assert property (wr_free_r <= 3'h4)
    else $error("write free count above four");
  a_fill_bound: assert property (rd_avail_r <= 4'h8)
    else $error("read fill count above depth");
  // With raw status and enables steady, masked status is their product.
  a_mask_view: assert property (($stable(int_raw_r) &&
    $stable(int_enable)) [*2] |-> int_masked_r == (int_raw_r & int_enable))
    else $error("masked status wrong");
  a_dma_idle: assert property (rd_avail_r == 4'h0 &&
    $past(rd_avail_r) == 4'h0 |-> !dma_req_r)
    else $error("dma request with empty fifo");
  // Outside a start the remaining count only steps down by one or clears.
  a_remain_step: assert property (!$past(str_start) &&
    !$past(str_start, 2) && str_remain_r != $past(str_remain_r)
    |-> str_remain_r == $past(str_remain_r) - 16'h0001 ||
    str_remain_r == 16'h0000) else $error("remaining count jumped");

  cover property (wr_free_r == 3'h0);
  cover property (rd_avail_r == 4'h8);
  cover property (err_status_r[0]);
endmodule
bind ebi_core ebi_core_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .cfg_mode(cfg_mode), .cfg_divider(cfg_divider),
  .cfg_max_wait(cfg_max_wait), .int_enable(int_enable),
  .str_start(str_start), .ext_ack(ext_ack), .ext_mode_r(ext_mode_r),
  .ext_clk_r(ext_clk_r), .ext_req_r(ext_req_r), .ext_addr_r(ext_addr_r),
  .wr_free_r(wr_free_r), .rd_avail_r(rd_avail_r),
  .str_remain_r(str_remain_r), .int_raw_r(int_raw_r),
  .int_masked_r(int_masked_r), .err_status_r(err_status_r),
  .dma_req_r(dma_req_r));
`default_nettype wire

/* test/ebi_ext_dev.sv */
// External device model: answers each bus request after a set delay.
// Assumes the core holds a request until answered and then drops it.
`timescale 1ns/100ps
`default_nettype none
module ebi_ext_dev (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Answer timing set by the bench.
  input wire logic [3:0] delay,
  input wire logic stall,
  // External bus.
  input wire logic ext_req_r,
  input wire logic ext_we_r,
  input wire logic [31:0] ext_addr_r,
  input wire logic [31:0] ext_wdata_r,
  output logic ext_ack,
  output logic [31:0] ext_rdata,
  // Log of completed writes.
  output logic [7:0] wr_cnt,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data
);
  logic [3:0] wait_r;
  // Answers for one cycle; data off the answer keeps changing.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_ack <= 1'b0;
      ext_rdata <= 32'h0;
      wait_r <= 4'h0;
      wr_cnt <= 8'h00;
      wr_addr <= 32'h0;
      wr_data <= 32'h0;
    end else if (ext_req_r && !ext_ack && !stall && wait_r == delay) begin
      ext_ack <= 1'b1;
      wait_r <= 4'h0;
      ext_rdata <= {ext_addr_r[15:0], ext_addr_r[15:0] ^ 16'hC3C3};
      if (ext_we_r) begin
        wr_cnt <= wr_cnt + 8'h01;
        wr_addr <= ext_addr_r;
        wr_data <= ext_wdata_r;
      end
    end else begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
      if (ext_req_r && !ext_ack && !stall) wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* test/external_bus_interface_tb.sv */
// Self-checking bench for the external bus interface core.
// Assumes the device model and the bound checker are compiled with it.
`include "ebi_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module external_bus_interface_tb;
  // ---
  // Signals and instances
  // ---
  logic sys_clk, reset_n, cpu_req, cpu_we, str_start, str_stop, rd_pop;
  logic cfg_wstall_err_en, cfg_rstall_err_en, stall, req_q;
  logic [1:0] cfg_mode, cfg_base, cfg_size, str_size;
  logic [2:0] cfg_wr_trig, int_enable, err_clear;
  logic [3:0] cfg_rd_trig, delay;
  logic [7:0] cfg_max_wait, wr_cnt;
  logic [15:0] cfg_divider, str_count;
  logic [31:0] cpu_addr, cpu_wdata, str_addr, wr_addr, wr_data, q;
  wire cpu_ready_r, rd_valid_r, irq_r, dma_req_r, ext_clk_r;
  wire ext_req_r, ext_we_r, ext_ack;
  wire [1:0] ext_mode_r;
  wire [2:0] wr_free_r, int_raw_r, int_masked_r, err_status_r;
  wire [3:0] rd_avail_r;
  wire [15:0] str_remain_r;
  wire [31:0] cpu_rdata_r, rd_data_r, ext_addr_r, ext_wdata_r, ext_rdata;
  int err_count, comparisons, nreq, maxst, n0;
  ebi_core u_dut (.*);
  ebi_ext_dev u_dev (.*);

  // Free-running system clock; bus requests are counted as they start.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    req_q <= ext_req_r;
    if (ext_req_r && !req_q) nreq++;
  end
  initial begin
    #(25 * 20000);
    err_count++;
    tally_and_finish;
  end
  // ---
  // Shared tasks
  // ---
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] pat(input logic [31:0] a);
    pat = {a[15:0], a[15:0] ^ 16'hC3C3};
  endfunction
  task cpu(input logic we, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    do @(posedge sys_clk); while (cpu_ready_r !== 1'b1 && n++ < 400);
    cpu_req <= 1'b0;
    if (n > maxst) maxst = n;
    if (!we) do @(posedge sys_clk); while (cpu_ready_r !== 1'b1 && n++ < 400);
    q = cpu_rdata_r;
  endtask
  task ign(input logic [31:0] a);
    n0 = nreq;
    @(posedge sys_clk);
    cpu_req <= 1'b1;
    cpu_we <= 1'b0;
    cpu_addr <= a;
    repeat (12) @(posedge sys_clk);
    cpu_req <= 1'b0;
    chk("ignored", n0, nreq);
  endtask
  task pop(input logic [31:0] e);
    int n;
    n = 0;
    do @(posedge sys_clk); while (rd_valid_r !== 1'b1 && n++ < 200);
    chk("item", e, rd_data_r);
    rd_pop <= 1'b1;
    @(posedge sys_clk);
    rd_pop <= 1'b0;
  endtask
  task stream(input logic [1:0] sz, input logic [15:0] cnt);
    @(posedge sys_clk);
    str_addr <= 32'h60000100;
    str_size <= sz;
    str_count <= cnt;
    @(posedge sys_clk);
    str_start <= 1'b1;
    @(posedge sys_clk);
    str_start <= 1'b0;
  endtask
  task pulse_clear(input logic [2:0] m);
    @(posedge sys_clk);
    err_clear <= m;
    @(posedge sys_clk);
    err_clear <= 3'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // ---
  // Scenarios
  // ---
  task t_writes;
    @(posedge sys_clk);
    delay <= 4'h8;
    cfg_wstall_err_en <= 1'b1;
    int_enable <= 3'h1;
    for (int i = 0; i < 6; i++) cpu(1'b1, 32'h60000000 + 4 * i, 32'h11111111 * i);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("free", 32'h0, wr_free_r);
    chk("stalled", 32'h1, maxst > 2);
    chk("wstall", 32'h1, err_status_r[2]);
    chk("irq", 32'h1, irq_r);
    pulse_clear(3'h4);
    chk("cleared", 32'h0, err_status_r[2]);
    repeat (120) @(posedge sys_clk);
    #1;
    chk("wcount", 32'h6, wr_cnt);
    chk("waddr", 32'h0014, wr_addr[15:0]);
    chk("wdata", 32'h55555555, wr_data);
    chk("free", 32'h4, wr_free_r);
  endtask
  task t_window;
    logic [31:0] a;
    logic [31:0] span [4];
    span = '{`EBI_SPAN_256B, `EBI_SPAN_64KB, `EBI_SPAN_16MB, `EBI_SPAN_512MB};
    @(posedge sys_clk);
    delay <= 4'h2;
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      cfg_base <= s[0] ? `EBI_BASE_6 : `EBI_BASE_8;
      cfg_size <= s[1:0];
      a = (s[0] ? `EBI_BASE_ADDR_6 : `EBI_BASE_ADDR_8) + span[s];
      cpu(1'b0, a, 32'h0);
      chk("rdata", pat(a), q);
      ign(a + 32'h1);
    end
    cfg_base <= `EBI_BASE_NONE;
    ign(`EBI_BASE_ADDR_6);
    @(posedge sys_clk);
    cfg_base <= `EBI_BASE_6;
  endtask
  task t_stream;
    for (int z = 0; z < 3; z++) begin
      n0 = nreq;
      stream(z[1:0], 16'h0003);
      for (int i = 0; i < 3; i++)
        pop(pat(32'h0100 + (i << z)) & (z == 2 ? ~32'h0 : (32'h1 << (8 << z)) - 1));
      repeat (6) @(posedge sys_clk);
      #1;
      chk("remain", 32'h0, str_remain_r);
      chk("avail", 32'h0, rd_avail_r);
      chk("reads", n0 + 3, nreq);
    end
  endtask
  task t_fill;
    @(posedge sys_clk);
    cfg_rd_trig <= 4'h4;
    int_enable <= 3'h2;
    stream(`EBI_ISZ_32, 16'h0010);
    repeat (80) @(posedge sys_clk);
    #1;
    chk("full", 32'h8, rd_avail_r);
    chk("paused", 32'h1, str_remain_r != 16'h0);
    chk("dma", 32'h1, dma_req_r);
    chk("rdirq", 32'h1, irq_r);
    chk("masked", 32'h2, int_masked_r);
    @(posedge sys_clk);
    str_stop <= 1'b1;
    @(posedge sys_clk);
    str_stop <= 1'b0;
    n0 = nreq;
    for (int i = 0; i < 8; i++) pop(pat(32'h0100 + 4 * i));
    repeat (3) @(posedge sys_clk);
    if (rd_valid_r === 1'b1) pop(pat(32'h0120));
    repeat (30) @(posedge sys_clk);
    #1;
    chk("stopped", n0, nreq);
    chk("dma off", 32'h0, dma_req_r);
  endtask
  task t_timeout;
    @(posedge sys_clk);
    stall <= 1'b1;
    cfg_max_wait <= 8'h03;
    int_enable <= 3'h1;
    cpu(1'b0, 32'h60000040, 32'h0);
    stall <= 1'b0;
    chk("tdata", 32'h0, q);
    #1;
    chk("timeout", 32'h1, err_status_r[0]);
    chk("terr", 32'h1, irq_r);
    pulse_clear(3'h1);
    chk("tclr", 32'h0, err_status_r[0]);
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      cfg_mode <= m[1:0];
      repeat (3) @(posedge sys_clk);
      #1;
      chk("mode", m[1:0], ext_mode_r);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Drives reset, checks reset values, then runs every scenario.
  initial begin
    {reset_n, cpu_req, cpu_we, str_start, str_stop, rd_pop, stall} = '0;
    {cfg_wstall_err_en, cfg_rstall_err_en, req_q, cfg_mode} = '0;
    {cfg_wr_trig, int_enable, err_clear, cfg_rd_trig, delay} = '0;
    {cfg_max_wait, cfg_divider, str_count, str_size} = '0;
    {cpu_addr, cpu_wdata, str_addr} = '0;
    cfg_base = `EBI_BASE_6;
    cfg_size = `EBI_SIZE_512MB;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("ready", 32'h1, cpu_ready_r);
    chk("free", 32'h4, wr_free_r);
    t_writes();
    t_window();
    t_stream();
    t_fill();
    t_timeout();
    t_modes();
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* verilog/ebi_core.v */
// External bus interface core: processor window, write FIFO, streaming
// read FIFO, bus clock divider, wait limit, interrupts and DMA request.
// Assumes one clock domain; the external device answers with ext_ack.
//
// Operation
// - Mode selects SDRAM, 8-bit host, 16-bit host or general purpose.
// - Divider value sets external bus clock rate from system clock.
// - Processor accesses inside the window become external transactions.
// - Writes with a full write FIFO stall until space frees.
// - Write FIFO holds four pending writes without stalling.
// - Software reads free write FIFO entries.
// - Programmed start address and count drive sequential reads into FIFO.
// - Start command begins streaming; stop command halts it early.
// - Software reads remaining streaming item count.
// - Software reads number of items available in read FIFO.
// - Streaming items are 32, 16 or 8 bits wide.
// - Both FIFOs have programmable trigger levels for service requests.
// - Enabled read or write stalls raise an error interrupt.
// - Sources individually enabled; raw and masked status readable.
// - Error status names the cause; each cause clears separately.
// - Read FIFO drains by polling, interrupt or DMA request.
// - Nonzero wait limit aborts the held transaction and interrupts.
// - Window base none, 0x6.., 0x8..; size 256B to 512MB.
`include "ebi_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module ebi_core (
  // Clock and reset.
  input wire sys_clk,
  input wire reset_n,
  // Configuration.
  input wire [1:0] cfg_mode,
  input wire [15:0] cfg_divider,
  input wire [1:0] cfg_base,
  input wire [1:0] cfg_size,
  input wire [7:0] cfg_max_wait,
  input wire [2:0] cfg_wr_trig,
  input wire [3:0] cfg_rd_trig,
  input wire cfg_wstall_err_en,
  input wire cfg_rstall_err_en,
  input wire [2:0] int_enable,
  input wire [2:0] err_clear,
  // Processor access port.
  input wire cpu_req,
  input wire cpu_we,
  input wire [31:0] cpu_addr,
  input wire [31:0] cpu_wdata,
  output reg cpu_ready_r,
  output reg [31:0] cpu_rdata_r,
  // Streaming read control, drain and FIFO levels.
  input wire [31:0] str_addr,
  input wire [15:0] str_count,
  input wire [1:0] str_size,
  input wire str_start,
  input wire str_stop,
  input wire rd_pop,
  output reg [31:0] rd_data_r,
  output reg rd_valid_r,
  output reg [15:0] str_remain_r,
  output reg [3:0] rd_avail_r,
  output reg [2:0] wr_free_r,
  // Interrupts, errors and DMA.
  output reg [2:0] int_raw_r,
  output reg [2:0] int_masked_r,
  output reg [2:0] err_status_r,
  output reg irq_r,
  output reg dma_req_r,
  // External bus.
  output reg ext_clk_r,
  output reg [1:0] ext_mode_r,
  output reg ext_req_r,
  output reg ext_we_r,
  output reg [31:0] ext_addr_r,
  output reg [31:0] ext_wdata_r,
  input wire ext_ack,
  input wire [31:0] ext_rdata
);

  // ----------------------------------------------------------------
  // Address window decode
  // ----------------------------------------------------------------
  reg [31:0] win_base;
  reg [31:0] win_span;
  wire in_win;

  // Base and span from the window selection.
  always @* begin
    case (cfg_base)
      `EBI_BASE_6: win_base = `EBI_BASE_ADDR_6;
      `EBI_BASE_8: win_base = `EBI_BASE_ADDR_8;
      default: win_base = 32'h00000000;
    endcase
    case (cfg_size)
      `EBI_SIZE_256B: win_span = `EBI_SPAN_256B;
      `EBI_SIZE_64KB: win_span = `EBI_SPAN_64KB;
      `EBI_SIZE_16MB: win_span = `EBI_SPAN_16MB;
      default: win_span = `EBI_SPAN_512MB;
    endcase
  end
  assign in_win = (cfg_base != `EBI_BASE_NONE) &&
                  ((cpu_addr & ~win_span) == win_base);

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  reg [15:0] div_cnt_r;
  wire bus_tick;
  assign bus_tick = (div_cnt_r == cfg_divider);

  // Divider counter; the external clock toggles on each wrap.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r <= `EBI_DIV_RESET;
      ext_clk_r <= 1'b0;
      ext_mode_r <= `EBI_MODE_SDRAM;
    end else begin
      ext_mode_r <= cfg_mode;
      if (bus_tick) begin
        div_cnt_r <= 16'h0000;
        ext_clk_r <= ~ext_clk_r;
      end else begin
        div_cnt_r <= div_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write transaction FIFO, four entries
  // ----------------------------------------------------------------
  reg [63:0] wf_mem [0:3];
  reg [1:0] wf_wp_r;
  reg [1:0] wf_rp_r;
  reg [2:0] wf_cnt_r;
  wire wf_full;
  wire wf_push;
  wire wf_pop;
  wire cpu_wr;
  wire cpu_rd;
  assign cpu_wr = cpu_req && cpu_we && in_win && cpu_ready_r;
  assign cpu_rd = cpu_req && !cpu_we && in_win && cpu_ready_r;
  assign wf_full = (wf_cnt_r == `EBI_WFIFO_DEPTH);
  assign wf_push = cpu_wr && !wf_full;
  // Count after this edge; ready must fall at the same edge the fourth entry lands,
  // because a registered ready seen high at an edge means the write is taken.
  wire [2:0] wf_cnt_nxt;
  assign wf_cnt_nxt = wf_cnt_r + {2'h0, wf_push} - {2'h0, wf_pop};

  // ----------------------------------------------------------------
  // Read FIFO, eight entries with a two-entry output buffer
  // ----------------------------------------------------------------
  reg [31:0] rf_mem [0:7];
  reg [2:0] rf_wp_r;
  reg [2:0] rf_rp_r;
  reg [3:0] rf_cnt_r;
  wire rf_full;
  wire rf_push;
  wire rf_pop;
  reg [31:0] ob_data_r [0:1];
  reg [1:0] ob_cnt_r;
  wire ob_ready;
  // The output buffer counts against the depth, so readable items stay <= 8.
  assign rf_full = ((rf_cnt_r + {2'h0, ob_cnt_r}) == `EBI_RFIFO_DEPTH);
  assign ob_ready = (ob_cnt_r != 2'h2);
  assign rf_pop = (rf_cnt_r != 4'h0) && ob_ready;

  // ----------------------------------------------------------------
  // External transaction engine
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WR = 2'h1;
  localparam ST_RD = 2'h2;
  localparam ST_STR = 2'h3;
  reg [1:0] st_r;
  reg [7:0] wait_r;
  reg str_act_r;
  reg [31:0] str_ptr_r;
  reg cpu_rd_pend_r;
  reg [31:0] cpu_rd_addr_r;
  wire [31:0] str_step;
  wire timeout;
  assign str_step = (str_size == `EBI_ISZ_8) ? 32'h00000001 :
                    (str_size == `EBI_ISZ_16) ? 32'h00000002 : 32'h00000004;
  assign timeout = (cfg_max_wait != 8'h00) && (wait_r == cfg_max_wait) &&
                   bus_tick && !ext_ack;
  assign wf_pop = (st_r == ST_IDLE) && (wf_cnt_r != 3'h0) && bus_tick;
  assign rf_push = (st_r == ST_STR) && ext_ack;
  wire rd_go;
  wire str_go;
  assign rd_go = (st_r == ST_IDLE) && bus_tick && (wf_cnt_r == 3'h0) &&
                 cpu_rd_pend_r;
  assign str_go = (st_r == ST_IDLE) && bus_tick && (wf_cnt_r == 3'h0) &&
                  !cpu_rd_pend_r && str_act_r && !rf_full &&
                  (str_remain_r != 16'h0000);

  // Transaction state machine; writes drain first, then CPU reads, then
  // stream reads, which keeps write ordering ahead of any read.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      wait_r <= 8'h00;
      ext_req_r <= 1'b0;
      ext_we_r <= 1'b0;
      ext_addr_r <= 32'h00000000;
      ext_wdata_r <= 32'h00000000;
    end else begin
      case (st_r)
        ST_IDLE: begin
          wait_r <= 8'h00;
          if (wf_pop) begin
            st_r <= ST_WR;
            ext_req_r <= 1'b1;
            ext_we_r <= 1'b1;
            ext_addr_r <= wf_mem[wf_rp_r][63:32];
            ext_wdata_r <= wf_mem[wf_rp_r][31:0];
          end else if (rd_go) begin
            st_r <= ST_RD;
            ext_req_r <= 1'b1;
            ext_we_r <= 1'b0;
            ext_addr_r <= cpu_rd_addr_r;
          end else if (str_go) begin
            st_r <= ST_STR;
            ext_req_r <= 1'b1;
            ext_we_r <= 1'b0;
            ext_addr_r <= str_ptr_r;
          end
        end
        default: begin
          if (ext_ack || timeout) begin
            st_r <= ST_IDLE;
            ext_req_r <= 1'b0;
            ext_we_r <= 1'b0;
          end else if (bus_tick) begin
            wait_r <= wait_r + 8'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Processor side, FIFOs and stream control
  // ----------------------------------------------------------------
  wire wr_stall;
  wire rd_stall;
  wire rd_done;
  wire rf_take;
  assign wr_stall = cpu_req && cpu_we && in_win && wf_full;
  assign rd_stall = cpu_rd_pend_r;
  assign rd_done = (st_r == ST_RD) && (ext_ack || timeout);
  assign rf_take = rd_pop && rd_valid_r;

  // Buffer pointers, counts, stream and CPU handshake.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wf_wp_r <= 2'h0;
      wf_rp_r <= 2'h0;
      wf_cnt_r <= 3'h0;
      rf_wp_r <= 3'h0;
      rf_rp_r <= 3'h0;
      rf_cnt_r <= 4'h0;
      ob_cnt_r <= 2'h0;
      ob_data_r[0] <= 32'h00000000;
      ob_data_r[1] <= 32'h00000000;
      str_act_r <= 1'b0;
      str_ptr_r <= 32'h00000000;
      str_remain_r <= 16'h0000;
      cpu_rd_pend_r <= 1'b0;
      cpu_rd_addr_r <= 32'h00000000;
      cpu_ready_r <= 1'b1;
      cpu_rdata_r <= 32'h00000000;
    end else begin
      // Write FIFO; a full FIFO drops ready until an entry drains.
      if (wf_push) begin
        wf_mem[wf_wp_r] <= {cpu_addr, cpu_wdata};
        wf_wp_r <= wf_wp_r + 2'h1;
      end
      if (wf_pop)
        wf_rp_r <= wf_rp_r + 2'h1;
      wf_cnt_r <= wf_cnt_r + {2'h0, wf_push} - {2'h0, wf_pop};
      // CPU reads block until the external answer returns or the wait limit times out.
      if (cpu_rd) begin
        cpu_rd_pend_r <= 1'b1;
        cpu_rd_addr_r <= cpu_addr;
      end else if (rd_done) begin
        cpu_rd_pend_r <= 1'b0;
        cpu_rdata_r <= ext_ack ? ext_rdata : 32'h00000000;
      end
      cpu_ready_r <= !(wr_stall || (wf_cnt_nxt == `EBI_WFIFO_DEPTH) || cpu_rd ||
                       (cpu_rd_pend_r && !rd_done));
      // Stream control; stop wins over an in-progress count.
      if (str_stop) begin
        str_act_r <= 1'b0;
      end else if (str_start) begin
        str_act_r <= 1'b1;
        str_ptr_r <= str_addr;
        str_remain_r <= str_count;
      end else if (st_r == ST_STR && (ext_ack || timeout)) begin
        str_ptr_r <= str_ptr_r + str_step;
        str_remain_r <= str_remain_r - 16'h0001;
        if (str_remain_r == 16'h0001)
          str_act_r <= 1'b0;
      end
      // Read FIFO storage, item sized to the chosen width.
      if (rf_push) begin
        case (str_size)
          `EBI_ISZ_8: rf_mem[rf_wp_r] <= {24'h000000, ext_rdata[7:0]};
          `EBI_ISZ_16: rf_mem[rf_wp_r] <= {16'h0000, ext_rdata[15:0]};
          default: rf_mem[rf_wp_r] <= ext_rdata;
        endcase
        rf_wp_r <= rf_wp_r + 3'h1;
      end
      if (rf_pop)
        rf_rp_r <= rf_rp_r + 3'h1;
      rf_cnt_r <= rf_cnt_r + {3'h0, rf_push} - {3'h0, rf_pop};
      // Two-entry output buffer; a stalled drain loses no item.
      if (rf_take)
        ob_data_r[0] <= ob_data_r[1];
      if (rf_pop) begin
        if (ob_cnt_r == 2'h0 || (ob_cnt_r == 2'h1 && rf_take))
          ob_data_r[0] <= rf_mem[rf_rp_r];
        else
          ob_data_r[1] <= rf_mem[rf_rp_r];
      end
      ob_cnt_r <= ob_cnt_r + {1'b0, rf_pop} - {1'b0, rf_take};
    end
  end

  // ----------------------------------------------------------------
  // Status, errors, interrupts and DMA
  // ----------------------------------------------------------------
  wire [2:0] err_set;
  wire [2:0] src;
  wire [3:0] avail_nxt;
  assign err_set = {wr_stall && cfg_wstall_err_en,
                    rd_stall && cfg_rstall_err_en, timeout};
  assign avail_nxt = rf_cnt_r + {2'h0, ob_cnt_r} - {3'h0, rf_take};
  assign src = {wf_cnt_r <= cfg_wr_trig,
                rf_cnt_r >= cfg_rd_trig && rf_cnt_r != 4'h0,
                err_status_r != 3'h0};

  // Registered status outputs; error set wins over a same-cycle clear.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_status_r <= 3'h0;
      int_raw_r <= 3'h0;
      int_masked_r <= 3'h0;
      irq_r <= 1'b0;
      dma_req_r <= 1'b0;
      wr_free_r <= `EBI_WFIFO_DEPTH;
      rd_avail_r <= 4'h0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 32'h00000000;
    end else begin
      err_status_r <= (err_status_r & ~err_clear) | err_set;
      int_raw_r <= src;
      int_masked_r <= src & int_enable;
      irq_r <= |(src & int_enable);
      dma_req_r <= src[`EBI_INT_RD];
      wr_free_r <= `EBI_WFIFO_DEPTH - wf_cnt_r -
                   {2'h0, wf_push} + {2'h0, wf_pop};
      rd_avail_r <= avail_nxt;
      rd_valid_r <= (ob_cnt_r + {1'b0, rf_pop} - {1'b0, rf_take}) != 2'h0;
      if (rf_take)
        rd_data_r <= (ob_cnt_r == 2'h2 || rf_pop) ?
                     ((ob_cnt_r == 2'h2) ? ob_data_r[1] : rf_mem[rf_rp_r]) :
                     rd_data_r;
      else if (!rd_valid_r && rf_pop)
        rd_data_r <= rf_mem[rf_rp_r];
    end
  end

endmodule
`default_nettype wire

/* verilog/ebi_regs.vh */
// Constants for the external bus interface block.
// Assumes inclusion by the design file and the bench; holds definitions only.
`ifndef EBI_REGS_VH
`define EBI_REGS_VH
// Operating modes.
`define EBI_MODE_SDRAM 2'h0
`define EBI_MODE_HB8 2'h1
`define EBI_MODE_HB16 2'h2
`define EBI_MODE_GP 2'h3
// Window base selections.
`define EBI_BASE_NONE 2'h0
`define EBI_BASE_6 2'h1
`define EBI_BASE_8 2'h2
`define EBI_BASE_ADDR_6 32'h60000000
`define EBI_BASE_ADDR_8 32'h80000000
// Window size selections and address bits covered.
`define EBI_SIZE_256B 2'h0
`define EBI_SIZE_64KB 2'h1
`define EBI_SIZE_16MB 2'h2
`define EBI_SIZE_512MB 2'h3
`define EBI_SPAN_256B 32'h000000FF
`define EBI_SPAN_64KB 32'h0000FFFF
`define EBI_SPAN_16MB 32'h00FFFFFF
`define EBI_SPAN_512MB 32'h1FFFFFFF
// Buffer depths.
`define EBI_WFIFO_DEPTH 3'h4
`define EBI_RFIFO_DEPTH 4'h8
// Read item sizes.
`define EBI_ISZ_8 2'h0
`define EBI_ISZ_16 2'h1
`define EBI_ISZ_32 2'h2
// Error cause bit positions.
`define EBI_ERR_TIMEOUT 0
`define EBI_ERR_RSTALL 1
`define EBI_ERR_WSTALL 2
// Interrupt source bit positions.
`define EBI_INT_ERR 0
`define EBI_INT_RD 1
`define EBI_INT_WR 2
// Reset values.
`define EBI_DIV_RESET 16'h0000
`endif
